// File: hw/lane_err_counter.sv
// one saturating error counter for one lane and one error kind
`timescale 1ns/1ps
`default_nettype none
module lane_err_counter
    import lane_mon_pkg::*;
#(
    parameter int COUNT_W = 8
) (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic err_pulse, // one error event
    input wire logic stop_cmd, // freeze this counter
    input wire logic zero_cmd, // clear count and release freeze
    input wire logic [COUNT_W-1:0] limit, // error count threshold
    output logic [COUNT_W-1:0] count, // current count
    output logic limit_hit // count has reached limit
);

    // refused at elaboration: the count must fit one register byte
    if (COUNT_W < 1 || COUNT_W > DATA_W) begin : g_bad_width
        $error("lane_err_counter: COUNT_W must be 1..8");
    end

    logic [COUNT_W-1:0] count_reg, count_next;
    logic stopped_reg, stopped_next;
    logic hit_reg, hit_next;

    // next state; a zero wins over an event in the same cycle
    always_comb begin
        count_next = count_reg;
        stopped_next = stopped_reg;
        if (zero_cmd) begin
            count_next = '0;
            stopped_next = 1'b0;
        end else if (stop_cmd) begin
            stopped_next = 1'b1;
        end else if (err_pulse && !stopped_reg && count_reg != '1) begin
            count_next = count_reg + COUNT_W'(1); // saturates so hit cannot fall back by wrap
        end
        // compare against the value being stored so limit_hit changes in the same cycle as count
        hit_next = (count_next >= limit);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_reg <= '0;
            stopped_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            stopped_reg <= stopped_next;
            hit_reg <= hit_next;
        end
    end

    assign count = count_reg;
    assign limit_hit = hit_reg;

endmodule
`default_nettype wire

// File: hw/lane_mon_pkg.sv
// constants and carrier types for the serial lane error monitor
package lane_mon_pkg;

    localparam int LANE_COUNT = 8;
    localparam int KIND_COUNT = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [11:0] ADDR_COUNTER_SELECT = 12'h46A;
    localparam logic [11:0] ADDR_COUNTER_READBACK = 12'h46B;
    localparam logic [11:0] ADDR_DISPARITY_CTRL = 12'h46D;
    localparam logic [11:0] ADDR_TABLE_MISS_CTRL = 12'h46E;
    localparam logic [11:0] ADDR_STRAY_CTRL_CTRL = 12'h46F;
    localparam logic [11:0] ADDR_CODE_GROUP_FLAGS = 12'h470;
    localparam logic [11:0] ADDR_FRAME_FLAGS = 12'h471;
    localparam logic [11:0] ADDR_CHECKSUM_FLAGS = 12'h472;
    localparam logic [11:0] ADDR_RAW_LOCK = 12'h474;
    localparam logic [11:0] ADDR_IRQ_VECTOR = 12'h47A;
    localparam logic [11:0] ADDR_ERROR_LIMIT = 12'h47C;

    // error control register fields
    localparam int BIT_CLEAR_IRQ = 7;
    localparam int BIT_STOP_COUNTER = 6;
    localparam int BIT_ZERO_COUNTER = 5;
    localparam int LANE_PICK_LSB = 0;
    localparam int LANE_PICK_W = 3;

    // indirect counter select fields
    localparam int SEL_LANE_LSB = 4;
    localparam int SEL_KIND_LSB = 0;
    localparam int SEL_KIND_W = 2;

    // flag register fields
    localparam int BIT_FLAG_IRQ_CLEAR = 7;
    localparam int BIT_CODE_GROUP_IRQ = 0;
    localparam int BIT_FRAME_IRQ = 1;
    localparam int BIT_CHECKSUM_IRQ = 2;

    // irq vector fields: flag on read, enable on write
    localparam int BIT_VEC_DISPARITY = 7;
    localparam int BIT_VEC_TABLE_MISS = 6;
    localparam int BIT_VEC_STRAY_CTRL = 5;

    // reset values
    localparam logic [7:0] RESET_ERROR_LIMIT = 8'hFF;
    localparam logic [7:0] RESET_COUNTER_SELECT = 8'h00;
    localparam logic [2:0] RESET_IRQ_ENABLE = 3'h0;

    // counter kinds in select-field order
    typedef enum logic [1:0] {
        KIND_DISPARITY,
        KIND_TABLE_MISS,
        KIND_STRAY_CTRL
    } counter_kind_e;

    // per-lane error event pulses from the lane decoders
    typedef struct packed {
        logic [LANE_COUNT-1:0] disparity;
        logic [LANE_COUNT-1:0] table_miss;
        logic [LANE_COUNT-1:0] stray_ctrl;
    } lane_errors_s;

    // per-lane live link status
    typedef struct packed {
        logic [LANE_COUNT-1:0] code_group_lock;
        logic [LANE_COUNT-1:0] frame_lock;
        logic [LANE_COUNT-1:0] checksum_ok;
    } lane_status_s;

    // register access request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

endpackage

// File: hw/serial_lane_error_monitor.sv
// per-lane error counters, threshold status and link sync flag registers
// Summary of operation
// - disparity bit7 write clears addressed lane's irq
// - disparity bit6 write stops addressed lane counter
// - disparity bit5 write zeroes addressed lane counter
// - bits[2:0] pick the lane for actions
// - disparity read shows per-lane threshold reached
// - counts readable through indirect readback register
// - dual link uses bits[3:0] per link
// - other kinds: bit7 write clears lane irq
// - other kinds: bit6 write stops lane counter
// - other kinds: bit5 write zeroes lane counter
// - table-miss read shows per-lane threshold reached
// - code group flags show lock of lanes 7:3, with the three irqs in bits[2:0]
// - bit7 write clears each flag register's irq
// - code group loss irq at flags bit0
// - any lane losing lock requests sync
// - frame flags show live per-lane frame lock
// - frame lock loss starts resync automatically
// - checksum flags per lane, irq at bit2
// - threshold comes from programmable limit register
// - enabled kind reaching threshold pulls irq low
// - kind select: 0 disparity, 1 miss, 2 stray
`timescale 1ns/1ps
`default_nettype none
module serial_lane_error_monitor
    import lane_mon_pkg::*;
#(
    parameter int LANES = LANE_COUNT,
    parameter int COUNT_W = 8
) (
    input wire logic core_clk, // system clock, 100 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire reg_req_s reg_req, // register write/read request
    output logic [DATA_W-1:0] reg_rdata, // read data, one cycle after rd_en
    input wire lane_errors_s lane_errors, // per-lane error pulses
    input wire lane_status_s lane_status, // per-lane live sync status
    input wire logic dual_link, // receiver split into two links
    input wire logic link_pick, // in dual link mode, link shown on reads
    output logic sync_request, // sync request toward transmitter
    output logic resync_start, // one-cycle pulse to restart link sync
    output logic irq_n // interrupt, active low
);

    // refused at elaboration: lane bits map one to one onto register bits
    if (LANES != LANE_COUNT) begin : g_bad_lanes
        $error("serial_lane_error_monitor: LANES must be 8");
    end
    if (COUNT_W < 1 || COUNT_W > DATA_W) begin : g_bad_width
        $error("serial_lane_error_monitor: COUNT_W must be 1..8");
    end

    localparam int HALF = LANES / 2;

    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANE_PICK_W-1:0] lane_pick;
    logic [KIND_COUNT-1:0] ctrl_wr;
    logic [KIND_COUNT-1:0][LANES-1:0] clear_irq, stop_cmd, zero_cmd;
    logic [KIND_COUNT-1:0][LANES-1:0] err_in;
    logic [KIND_COUNT-1:0][LANES-1:0] hit;
    logic [COUNT_W-1:0] count [KIND_COUNT][LANES];

    assign wr_en = reg_req.wr_en;
    assign rd_en = reg_req.rd_en;
    assign addr = reg_req.addr;
    assign wdata = reg_req.wdata;
    assign lane_pick = wdata[LANE_PICK_LSB +: LANE_PICK_W];
    assign err_in[KIND_DISPARITY] = lane_errors.disparity;
    assign err_in[KIND_TABLE_MISS] = lane_errors.table_miss;
    assign err_in[KIND_STRAY_CTRL] = lane_errors.stray_ctrl;

    // write strobes of the three error control registers
    always_comb begin
        ctrl_wr = '0;
        if (wr_en && addr == ADDR_DISPARITY_CTRL) begin
            ctrl_wr[KIND_DISPARITY] = 1'b1;
        end else if (wr_en && addr == ADDR_TABLE_MISS_CTRL) begin
            ctrl_wr[KIND_TABLE_MISS] = 1'b1;
        end else if (wr_en && addr == ADDR_STRAY_CTRL_CTRL) begin
            ctrl_wr[KIND_STRAY_CTRL] = 1'b1;
        end
    end

    logic [DATA_W-1:0] error_limit_reg, error_limit_next;
    logic [DATA_W-1:0] counter_select_reg, counter_select_next;
    logic [KIND_COUNT-1:0] irq_enable_reg, irq_enable_next;
    logic [KIND_COUNT-1:0][LANES-1:0] lane_irq_reg, lane_irq_next;
    logic [KIND_COUNT-1:0][LANES-1:0] hit_prev_reg;

    // per kind and lane: decode actions, count, and keep a sticky irq
    for (genvar k = 0; k < KIND_COUNT; k++) begin : g_kind
        for (genvar l = 0; l < LANES; l++) begin : g_lane
            assign clear_irq[k][l] = ctrl_wr[k] && wdata[BIT_CLEAR_IRQ] && lane_pick == l;
            assign stop_cmd[k][l] = ctrl_wr[k] && wdata[BIT_STOP_COUNTER] && lane_pick == l;
            assign zero_cmd[k][l] = ctrl_wr[k] && wdata[BIT_ZERO_COUNTER] && lane_pick == l;

            lane_err_counter #(
                .COUNT_W(COUNT_W)
            ) u_counter (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .err_pulse(err_in[k][l]),
                .stop_cmd(stop_cmd[k][l]),
                .zero_cmd(zero_cmd[k][l]),
                .limit(error_limit_reg[COUNT_W-1:0]),
                .count(count[k][l]),
                .limit_hit(hit[k][l])
            );

            // irq raised on reaching the limit; a raise beats a clear in the same cycle
            always_comb begin
                lane_irq_next[k][l] = lane_irq_reg[k][l];
                if (clear_irq[k][l]) begin
                    lane_irq_next[k][l] = 1'b0;
                end
                if (hit[k][l] && !hit_prev_reg[k][l]) begin
                    lane_irq_next[k][l] = 1'b1;
                end
            end
        end
    end

    // software-held settings
    always_comb begin
        error_limit_next = error_limit_reg;
        counter_select_next = counter_select_reg;
        irq_enable_next = irq_enable_reg;
        if (wr_en && addr == ADDR_ERROR_LIMIT) begin
            error_limit_next = wdata;
        end else if (wr_en && addr == ADDR_COUNTER_SELECT) begin
            counter_select_next = wdata;
        end else if (wr_en && addr == ADDR_IRQ_VECTOR) begin
            irq_enable_next[KIND_DISPARITY] = wdata[BIT_VEC_DISPARITY];
            irq_enable_next[KIND_TABLE_MISS] = wdata[BIT_VEC_TABLE_MISS];
            irq_enable_next[KIND_STRAY_CTRL] = wdata[BIT_VEC_STRAY_CTRL];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            error_limit_reg <= RESET_ERROR_LIMIT;
            counter_select_reg <= RESET_COUNTER_SELECT;
            irq_enable_reg <= RESET_IRQ_ENABLE;
            lane_irq_reg <= '0;
            hit_prev_reg <= '0;
        end else begin
            error_limit_reg <= error_limit_next;
            counter_select_reg <= counter_select_next;
            irq_enable_reg <= irq_enable_next;
            lane_irq_reg <= lane_irq_next;
            hit_prev_reg <= hit;
        end
    end

    // link flag state: previous status for loss detection and three sticky irqs
    logic [LANES-1:0] cg_prev_reg, fr_prev_reg, cs_prev_reg;
    logic cg_irq_reg, cg_irq_next;
    logic fr_irq_reg, fr_irq_next;
    logic cs_irq_reg, cs_irq_next;
    logic cg_loss, fr_loss, cs_loss;
    logic sync_request_reg, sync_request_next;
    logic resync_start_reg, resync_start_next;

    assign cg_loss = |(cg_prev_reg & ~lane_status.code_group_lock);
    assign fr_loss = |(fr_prev_reg & ~lane_status.frame_lock);
    assign cs_loss = |(cs_prev_reg & ~lane_status.checksum_ok);

    // loss sets the irq even when the clearing write lands in the same cycle
    always_comb begin
        cg_irq_next = cg_irq_reg;
        fr_irq_next = fr_irq_reg;
        cs_irq_next = cs_irq_reg;
        if (wr_en && addr == ADDR_CODE_GROUP_FLAGS && wdata[BIT_FLAG_IRQ_CLEAR]) begin
            cg_irq_next = 1'b0;
        end
        if (wr_en && addr == ADDR_FRAME_FLAGS && wdata[BIT_FLAG_IRQ_CLEAR]) begin
            fr_irq_next = 1'b0;
        end
        if (wr_en && addr == ADDR_CHECKSUM_FLAGS && wdata[BIT_FLAG_IRQ_CLEAR]) begin
            cs_irq_next = 1'b0;
        end
        if (cg_loss) begin
            cg_irq_next = 1'b1;
        end
        if (fr_loss) begin
            fr_irq_next = 1'b1;
        end
        if (cs_loss) begin
            cs_irq_next = 1'b1;
        end
        // request held while any lane is out of code group lock
        sync_request_next = ~&lane_status.code_group_lock;
        resync_start_next = fr_loss;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cg_prev_reg <= '0;
            fr_prev_reg <= '0;
            cs_prev_reg <= '0;
            cg_irq_reg <= 1'b0;
            fr_irq_reg <= 1'b0;
            cs_irq_reg <= 1'b0;
            sync_request_reg <= 1'b1;
            resync_start_reg <= 1'b0;
        end else begin
            cg_prev_reg <= lane_status.code_group_lock;
            fr_prev_reg <= lane_status.frame_lock;
            cs_prev_reg <= lane_status.checksum_ok;
            cg_irq_reg <= cg_irq_next;
            fr_irq_reg <= fr_irq_next;
            cs_irq_reg <= cs_irq_next;
            sync_request_reg <= sync_request_next;
            resync_start_reg <= resync_start_next;
        end
    end

    // per-lane view as seen by software; dual link folds the picked half into bits [3:0]
    function automatic logic [DATA_W-1:0] lane_view(input logic [LANES-1:0] bits_in, input logic dual,
                                                    input logic pick);
        logic [DATA_W-1:0] v;
        v = '0;
        if (dual) begin
            v[HALF-1:0] = pick ? bits_in[LANES-1:HALF] : bits_in[HALF-1:0];
        end else begin
            v[LANES-1:0] = bits_in;
        end
        return v;
    endfunction

    // indirect counter readback
    logic [LANE_PICK_W-1:0] sel_lane;
    logic [SEL_KIND_W-1:0] sel_kind;
    logic [DATA_W-1:0] sel_count;

    assign sel_lane = counter_select_reg[SEL_LANE_LSB +: LANE_PICK_W];
    assign sel_kind = counter_select_reg[SEL_KIND_LSB +: SEL_KIND_W];

    always_comb begin
        sel_count = '0;
        if (sel_kind == KIND_DISPARITY) begin
            sel_count[COUNT_W-1:0] = count[KIND_DISPARITY][sel_lane];
        end else if (sel_kind == KIND_TABLE_MISS) begin
            sel_count[COUNT_W-1:0] = count[KIND_TABLE_MISS][sel_lane];
        end else if (sel_kind == KIND_STRAY_CTRL) begin
            sel_count[COUNT_W-1:0] = count[KIND_STRAY_CTRL][sel_lane];
        end
    end

    // read mux; unmapped addresses and the stray control register read as zero
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [DATA_W-1:0] cg_view;

    always_comb begin
        cg_view = lane_view(lane_status.code_group_lock, dual_link, link_pick);
        cg_view[BIT_CODE_GROUP_IRQ] = cg_irq_reg;
        cg_view[BIT_FRAME_IRQ] = fr_irq_reg;
        cg_view[BIT_CHECKSUM_IRQ] = cs_irq_reg;
        rdata_next = rdata_reg;
        if (rd_en) begin
            rdata_next = '0;
            if (addr == ADDR_DISPARITY_CTRL) begin
                rdata_next = lane_view(hit[KIND_DISPARITY], dual_link, link_pick);
            end else if (addr == ADDR_TABLE_MISS_CTRL) begin
                rdata_next = lane_view(hit[KIND_TABLE_MISS], dual_link, link_pick);
            end else if (addr == ADDR_COUNTER_READBACK) begin
                rdata_next = sel_count;
            end else if (addr == ADDR_CODE_GROUP_FLAGS) begin
                rdata_next = cg_view;
            end else if (addr == ADDR_FRAME_FLAGS) begin
                rdata_next = lane_view(lane_status.frame_lock, dual_link, link_pick);
            end else if (addr == ADDR_CHECKSUM_FLAGS) begin
                rdata_next = lane_view(lane_status.checksum_ok, dual_link, link_pick);
            end else if (addr == ADDR_RAW_LOCK) begin
                rdata_next = lane_view(lane_status.code_group_lock, dual_link, link_pick);
            end else if (addr == ADDR_IRQ_VECTOR) begin
                rdata_next[BIT_VEC_DISPARITY] = |lane_irq_reg[KIND_DISPARITY];
                rdata_next[BIT_VEC_TABLE_MISS] = |lane_irq_reg[KIND_TABLE_MISS];
                rdata_next[BIT_VEC_STRAY_CTRL] = |lane_irq_reg[KIND_STRAY_CTRL];
            end else if (addr == ADDR_ERROR_LIMIT) begin
                rdata_next = error_limit_reg;
            end else if (addr == ADDR_COUNTER_SELECT) begin
                rdata_next = counter_select_reg;
            end
        end
    end

    // interrupt output: any enabled kind with a pending lane irq
    logic irq_n_reg, irq_n_next;

    always_comb begin
        irq_n_next = 1'b1;
        for (int k = 0; k < KIND_COUNT; k++) begin
            if (irq_enable_reg[k] && |lane_irq_reg[k]) begin
                irq_n_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
            irq_n_reg <= 1'b1;
        end else begin
            rdata_reg <= rdata_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq_n = irq_n_reg;
    assign sync_request = sync_request_reg;
    assign resync_start = resync_start_reg;

endmodule
`default_nettype wire

// File: tb/lane_tx_model.sv
// behavioural transmitter: lane error events and live lane status
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model
    import lane_mon_pkg::*;
(
    input wire logic core_clk, // system clock
    output var lane_errors_s lane_errors, // error events toward receiver
    output var lane_status_s lane_status // live lane status
);
    // lanes start unlocked, as a transmitter before link-up
    initial begin
        lane_errors = '0;
        lane_status = '0;
    end
    // n one-cycle error events, low between them so each counts once
    task automatic send_errs(input int kind, input logic [2:0] lane, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            case (kind)
                0: lane_errors.disparity[lane] = 1'b1;
                1: lane_errors.table_miss[lane] = 1'b1;
                default: lane_errors.stray_ctrl[lane] = 1'b1;
            endcase
            @(negedge core_clk);
            lane_errors = '0;
        end
    endtask
    // status changes land off the sampling edge
    task automatic set_status(input logic [7:0] cg, input logic [7:0] fr, input logic [7:0] ck);
        @(negedge core_clk);
        lane_status = {cg, fr, ck};
    endtask
endmodule
`default_nettype wire

// File: tb/serial_lane_error_monitor_asserts.sv
// port-level checks for the lane error monitor
`timescale 1ns/1ps
`default_nettype none
module serial_lane_error_monitor_asserts
    import lane_mon_pkg::*;
#(
    parameter int LANES = LANE_COUNT,
    parameter int COUNT_W = 8
) (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire reg_req_s reg_req, // register request
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire lane_errors_s lane_errors, // error pulses
    input wire lane_status_s lane_status, // live status
    input wire logic dual_link, // two-link mode
    input wire logic link_pick, // link shown
    input wire logic sync_request, // sync request
    input wire logic resync_start, // resync pulse
    input wire logic irq_n // interrupt, active low
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // read strobes decoded once, reused below
    wire logic rd_go = reg_req.rd_en && !reg_req.wr_en;
    wire logic rd_frame = rd_go && reg_req.addr == ADDR_FRAME_FLAGS;
    wire logic rd_raw = rd_go && reg_req.addr == ADDR_RAW_LOCK;
    wire logic rd_stray = rd_go && reg_req.addr == ADDR_STRAY_CTRL_CTRL;

    // a fall is only seen once the previous-status copy has loaded out of reset
    sequence frame_drop;
        !$past(sys_rst) && (|($past(lane_status.frame_lock) & ~lane_status.frame_lock));
    endsequence
    sequence mask_off_write;
        reg_req.wr_en && reg_req.addr == ADDR_IRQ_VECTOR && reg_req.wdata[7:5] == 3'h0;
    endsequence

    chk_sync_follows_lock: assert property (!$past(sys_rst)
        |-> sync_request == !(&$past(lane_status.code_group_lock)))
        else $error("sync request does not follow lane lock");
    chk_resync_on_drop: assert property (frame_drop |=> resync_start)
        else $error("no resync pulse after frame lock fall");
    chk_resync_has_cause: assert property (resync_start
        |-> |($past(lane_status.frame_lock, 2) & ~$past(lane_status.frame_lock)))
        else $error("resync pulse without frame lock fall");
    chk_irq_masked_off: assert property (mask_off_write |-> ##2 irq_n)
        else $error("irq low with all kinds disabled");
    chk_rdata_holds: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_stray_read_zero: assert property (rd_stray |=> reg_rdata == 8'h00)
        else $error("stray control register read not zero");
    chk_frame_live_read: assert property (rd_frame && !dual_link && $stable(lane_status.frame_lock)
        |=> reg_rdata == $past(lane_status.frame_lock))
        else $error("frame flags read differs from live status");
    chk_raw_lock_read: assert property (rd_raw && !dual_link && $stable(lane_status.code_group_lock)
        |=> reg_rdata == $past(lane_status.code_group_lock))
        else $error("raw lock read differs from live status");
    chk_dual_link_pick: assert property (rd_frame && dual_link && $stable(lane_status.frame_lock)
        |=> reg_rdata[3:0] == ($past(link_pick) ? $past(lane_status.frame_lock[7:4])
        : $past(lane_status.frame_lock[3:0])))
        else $error("dual link read shows wrong lanes");
endmodule

bind serial_lane_error_monitor serial_lane_error_monitor_asserts #(.LANES(LANES), .COUNT_W(COUNT_W)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .lane_errors(lane_errors), .lane_status(lane_status), .dual_link(dual_link), .link_pick(link_pick),
    .sync_request(sync_request), .resync_start(resync_start), .irq_n(irq_n));
`default_nettype wire

// File: tb/serial_lane_error_monitor_tb_top.sv
// self-checking bench for the lane error monitor
`timescale 1ns/1ps
`default_nettype none
module serial_lane_error_monitor_tb_top
    import lane_mon_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_s reg_req = '0;
    logic [DATA_W-1:0] reg_rdata;
    lane_errors_s lane_errors;
    lane_status_s lane_status;
    logic dual_link = 1'b0;
    logic link_pick = 1'b0;
    logic sync_request;
    logic resync_start;
    logic irq_n;
    int err_total = 0;
    int num_checks = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    serial_lane_error_monitor dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .lane_errors(lane_errors), .lane_status(lane_status), .dual_link(dual_link),
        .link_pick(link_pick), .sync_request(sync_request), .resync_start(resync_start), .irq_n(irq_n));
    lane_tx_model far_end (.core_clk(core_clk), .lane_errors(lane_errors), .lane_status(lane_status));

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes rise and fall at falling edges, so one rising edge takes them
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = {1'b1, 1'b0, a, d};
        @(negedge core_clk);
        reg_req = '0;
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_req = {1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        reg_req = '0;
        check8(what, exp, reg_rdata);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic test_reset();
        check8("sync_request", 8'h01, {7'h00, sync_request});
        check8("irq_n", 8'h01, {7'h00, irq_n});
        rd_chk("disparity status", ADDR_DISPARITY_CTRL, 8'h00);
        rd_chk("table miss status", ADDR_TABLE_MISS_CTRL, 8'h00);
        rd_chk("error limit", ADDR_ERROR_LIMIT, RESET_ERROR_LIMIT);
        rd_chk("unmapped", 12'h46C, 8'h00);
        $display("test reset done");
    endtask

    // count to the limit, irq, clear, zero, stop, all through one kind
    task automatic test_kind(input int k);
        logic [11:0] ctl;
        logic [2:0] ln;
        logic [7:0] st;
        ctl = ADDR_DISPARITY_CTRL + 12'(k);
        ln = 3'(3 * k + 1);
        st = (k == 2) ? 8'h00 : (8'h01 << ln); // stray status is not readable
        reg_wr(ADDR_ERROR_LIMIT, 8'h03);
        reg_wr(ADDR_IRQ_VECTOR, 8'h80 >> k);
        reg_wr(ADDR_COUNTER_SELECT, {1'b0, ln, 2'h0, 2'(k)});
        far_end.send_errs(k, ln, 2);
        rd_chk("count below limit", ADDR_COUNTER_READBACK, 8'h02);
        rd_chk("status below limit", ctl, 8'h00);
        check8("irq_n below limit", 8'h01, {7'h00, irq_n});
        far_end.send_errs(k, ln, 1);
        repeat (3) @(negedge core_clk);
        check8("irq_n at limit", 8'h00, {7'h00, irq_n});
        rd_chk("count at limit", ADDR_COUNTER_READBACK, 8'h03);
        rd_chk("status at limit", ctl, st);
        rd_chk("irq vector", ADDR_IRQ_VECTOR, 8'h80 >> k);
        reg_wr(ctl, {5'h10, ln});
        repeat (2) @(negedge core_clk);
        check8("irq_n cleared", 8'h01, {7'h00, irq_n});
        reg_wr(ctl, {5'h04, ln});
        rd_chk("count zeroed", ADDR_COUNTER_READBACK, 8'h00);
        rd_chk("status zeroed", ctl, 8'h00);
        reg_wr(ctl, {5'h08, ln});
        far_end.send_errs(k, ln, 2);
        far_end.send_errs(k, ln + 3'h1, 1);
        rd_chk("count stopped", ADDR_COUNTER_READBACK, 8'h00);
        reg_wr(ADDR_COUNTER_SELECT, {1'b0, ln + 3'h1, 2'h0, 2'(k)});
        rd_chk("neighbour lane counts", ADDR_COUNTER_READBACK, 8'h01);
        reg_wr(ctl, {5'h04, ln + 3'h1});
        reg_wr(ctl, {5'h04, ln}); // zero also releases the stop
        reg_wr(ADDR_IRQ_VECTOR, 8'h00);
        $display("test kind %0d done", k);
    endtask

    task automatic test_flags();
        far_end.set_status(8'hFF, 8'hFF, 8'hFF);
        repeat (3) @(negedge core_clk);
        check8("sync_request locked", 8'h00, {7'h00, sync_request});
        rd_chk("raw lock", ADDR_RAW_LOCK, 8'hFF);
        far_end.set_status(8'hF7, 8'hFF, 8'hFF);
        repeat (2) @(negedge core_clk);
        check8("sync_request lost", 8'h01, {7'h00, sync_request});
        rd_chk("code group flags", ADDR_CODE_GROUP_FLAGS, 8'hF1);
        reg_wr(ADDR_CODE_GROUP_FLAGS, 8'h80);
        rd_chk("cg irq cleared", ADDR_CODE_GROUP_FLAGS, 8'hF0);
        far_end.set_status(8'hF7, 8'hBF, 8'hFF);
        rd_chk("frame flags", ADDR_FRAME_FLAGS, 8'hBF);
        rd_chk("frame irq", ADDR_CODE_GROUP_FLAGS, 8'hF2);
        reg_wr(ADDR_FRAME_FLAGS, 8'h80);
        far_end.set_status(8'hF7, 8'hBF, 8'hFE);
        rd_chk("checksum flags", ADDR_CHECKSUM_FLAGS, 8'hFE);
        rd_chk("checksum irq", ADDR_CODE_GROUP_FLAGS, 8'hF4);
        reg_wr(ADDR_CHECKSUM_FLAGS, 8'h80);
        rd_chk("flags cleared", ADDR_CODE_GROUP_FLAGS, 8'hF0);
        @(negedge core_clk);
        dual_link = 1'b1;
        link_pick = 1'b1;
        rd_chk("upper link lanes", ADDR_FRAME_FLAGS, 8'h0B);
        link_pick = 1'b0;
        rd_chk("lower link lanes", ADDR_FRAME_FLAGS, 8'h0F);
        $display("test flags done");
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        test_reset();
        for (int k = 0; k < KIND_COUNT; k++)
            test_kind(k);
        test_flags();
        stop_test();
    end
    // watchdog, well past the few hundred cycles the tests need
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
